// file: hw/pcm_manager.sv
`timescale 1ns/100ps
`include "pcm_params.svh"
// Behaviour
// - Idle leaves on phy enabled plus open request
// - Idle goes connected on connection opened
// - Hard reset in request wait aborts to idle
// - Entry loads and starts arbitration wait timer
// - Entry issues open with eight request fields
// - Opened: notify controller, go connected
// - Opened by other: drop, retry with qualifier
// - Retry copies seven fields plus timer value
// - Blocked, retry, no destination give retry
// - Five reasons give cannot connect message
// - Inbound rejected after open gives collided retry
// - Cannot connect carries tag, destination, source
// - Cancel before opened sends stop arbitration
// - Failed or collided retry, cannot connect, reset, phy off: idle
// - Timeout, break, layer request: wait close
// - Power on starts in idle
module pcm_manager import pcm_pkg::*; (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_phy_enabled,
    input wire logic i_phy_disabled,
    input wire logic i_open_req,
    input wire pcm_open_s i_open,
    input wire logic i_cancel_open,
    input wire logic i_conn_opened,
    input wire logic i_opened_by_us,
    input wire logic i_opened_by_dest,
    input wire logic i_open_failed,
    input wire logic [3:0] i_fail_rsn,
    input wire logic i_inb_rejected,
    input wire logic i_hard_reset,
    input wire logic i_conn_done,
    output logic o_link_open,
    output pcm_open_s o_link_args,
    output logic o_link_stop_arb,
    output logic o_oc_opened,
    output logic o_oc_retry,
    output logic o_oc_nocon,
    output logic [3:0] o_oc_rsn,
    output pcm_open_s o_oc_args,
    output pcm_state_e o_state
);
    // ==========================================================
    // State
    typedef struct packed {
        pcm_state_e state;
        logic phy_on;
        logic opened_seen;
        pcm_open_s req;
        logic link_open;
        logic stop_arb;
        logic oc_opened;
        logic oc_retry;
        logic oc_nocon;
        logic [3:0] rsn;
        pcm_open_s oc_args;
    } pcm_mgr_s;
    pcm_mgr_s st_ff;
    pcm_mgr_s nxt_st;
    pcm_timer_if tif ();

    function automatic pcm_open_s retry_args(input pcm_open_s r,
                                             input logic [15:0] t);
        retry_args = r;
        retry_args.awt = t;
    endfunction : retry_args

    function automatic pcm_open_s nocon_args(input pcm_open_s r);
        nocon_args = '0;
        nocon_args.conn_tag = r.conn_tag;
        nocon_args.dest_addr = r.dest_addr;
        nocon_args.src_addr = r.src_addr;
    endfunction : nocon_args

    pcm_awt_timer u_tmr (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .tif(tif)
    );

    // ==========================================================
    // Next state; pulses last one enabled cycle and hold while enable is low
    always_comb begin
        nxt_st = st_ff;
        nxt_st.link_open = 1'b0;
        nxt_st.stop_arb = 1'b0;
        nxt_st.oc_opened = 1'b0;
        nxt_st.oc_retry = 1'b0;
        nxt_st.oc_nocon = 1'b0;
        tif.load = 1'b0;
        tif.run = (st_ff.state == MGR_REQUEST_WAIT_STATE);
        tif.init = st_ff.req.awt;
        // Phy status is tracked in every state
        if (i_phy_enabled)
            nxt_st.phy_on = 1'b1;
        if (i_phy_disabled)
            nxt_st.phy_on = 1'b0;
        case (st_ff.state)
            MGR_IDLE_STATE: begin
                if (i_conn_opened) begin
                    nxt_st.state = MGR_CONNECTED_STATE;
                end else if ((st_ff.phy_on || i_phy_enabled) && i_open_req
                             && !i_phy_disabled) begin
                    nxt_st.state = MGR_REQUEST_WAIT_STATE;
                    nxt_st.req = i_open;
                    nxt_st.opened_seen = 1'b0;
                    nxt_st.link_open = 1'b1;
                    tif.load = 1'b1;
                    tif.init = i_open.awt;
                end
            end
            MGR_REQUEST_WAIT_STATE: begin
                // Hard reset and phy loss outrank link outcomes
                if (i_hard_reset || i_phy_disabled) begin
                    nxt_st.state = MGR_IDLE_STATE;
                end else if (i_conn_opened) begin
                    nxt_st.opened_seen = 1'b1;
                    nxt_st.oc_opened = 1'b1;
                    nxt_st.state = MGR_CONNECTED_STATE;
                    if (!i_opened_by_us) begin
                        nxt_st.oc_retry = 1'b1;
                        nxt_st.rsn = i_opened_by_dest ? `PCM_RSN_BY_DEST
                                                      : `PCM_RSN_BY_OTHER;
                        nxt_st.oc_args = retry_args(st_ff.req,
                                                    tif.value);
                    end
                end else if (i_inb_rejected) begin
                    nxt_st.oc_retry = 1'b1;
                    nxt_st.rsn = `PCM_RSN_COLLIDED;
                    nxt_st.oc_args = retry_args(st_ff.req, tif.value);
                    nxt_st.state = MGR_IDLE_STATE;
                end else if (i_open_failed) begin
                    case (i_fail_rsn)
                        `PCM_RSN_PATH_BLOCKED, `PCM_RSN_RETRY,
                        `PCM_RSN_NO_DEST: begin
                            nxt_st.oc_retry = 1'b1;
                            nxt_st.rsn = i_fail_rsn;
                            nxt_st.oc_args = retry_args(st_ff.req,
                                                        tif.value);
                            nxt_st.state = MGR_IDLE_STATE;
                        end
                        `PCM_RSN_BAD_DEST, `PCM_RSN_RATE_NS,
                        `PCM_RSN_PROTO_NS, `PCM_RSN_TUN_BUSY,
                        `PCM_RSN_WRONG_DEST: begin
                            nxt_st.oc_nocon = 1'b1;
                            nxt_st.rsn = i_fail_rsn;
                            nxt_st.oc_args = nocon_args(st_ff.req);
                            nxt_st.state = MGR_IDLE_STATE;
                        end
                        `PCM_RSN_OPEN_TMO, `PCM_RSN_BREAK_RX,
                        `PCM_RSN_PL_REQ: begin
                            nxt_st.state = MGR_WAIT_CLOSE_STATE;
                        end
                        default: begin
                            nxt_st.state = st_ff.state;
                        end
                    endcase
                end else if (i_cancel_open && !st_ff.opened_seen) begin
                    nxt_st.stop_arb = 1'b1;
                end
            end
            // Connected and wait-close belong to other blocks; they
            // hand back idle through the done strobe, hard reset or phy loss
            default: begin
                if (i_conn_done || i_hard_reset || i_phy_disabled)
                    nxt_st.state = MGR_IDLE_STATE;
            end
        endcase
    end

    // ==========================================================
    // Register
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_ff <= '0;
            st_ff.state <= MGR_IDLE_STATE;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // Every output comes straight from the state register
    assign o_link_open = st_ff.link_open;
    assign o_link_args = st_ff.req;
    assign o_link_stop_arb = st_ff.stop_arb;
    assign o_oc_opened = st_ff.oc_opened;
    assign o_oc_retry = st_ff.oc_retry;
    assign o_oc_nocon = st_ff.oc_nocon;
    assign o_oc_rsn = st_ff.rsn;
    assign o_oc_args = st_ff.oc_args;
    assign o_state = st_ff.state;

    // ==========================================================
    // Checks
    sequence s_open_taken;
        st_ff.state == MGR_IDLE_STATE && i_ce && !i_conn_opened &&
        i_open_req && (st_ff.phy_on || i_phy_enabled) && !i_phy_disabled;
    endsequence
    a_open_issue: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        s_open_taken |=> o_link_open && o_state == MGR_REQUEST_WAIT_STATE
            && o_link_args == $past(i_open))
        else $error("open not issued");
    a_idle_conn: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_state == MGR_IDLE_STATE && i_ce && i_conn_opened
        |=> o_state == MGR_CONNECTED_STATE)
        else $error("idle did not connect");
    a_reset_idle: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_state == MGR_REQUEST_WAIT_STATE && i_ce && i_hard_reset
        |=> o_state == MGR_IDLE_STATE && !o_oc_retry)
        else $error("hard reset not honoured");
    a_timer_load: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        s_open_taken |=> tif.value == o_link_args.awt)
        else $error("timer not loaded");
    a_opened_msg: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_state == MGR_REQUEST_WAIT_STATE && i_ce && !i_hard_reset &&
        !i_phy_disabled && i_conn_opened
        |=> o_oc_opened && o_state == MGR_CONNECTED_STATE
            && o_oc_retry == !$past(i_opened_by_us))
        else $error("opened handling wrong");
    a_retry_args: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_oc_retry |-> o_oc_args.conn_tag == o_link_args.conn_tag &&
        o_oc_args.pbc == o_link_args.pbc)
        else $error("retry fields wrong");
    a_nocon_args: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_oc_nocon |-> o_oc_args.pbc == 16'h0 &&
        o_oc_args.src_addr == o_link_args.src_addr &&
        o_state == MGR_IDLE_STATE)
        else $error("cannot connect fields wrong");
    a_fail_wclose: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_state == MGR_REQUEST_WAIT_STATE && i_ce && !i_hard_reset &&
        !i_phy_disabled && !i_conn_opened && !i_inb_rejected &&
        i_open_failed && i_fail_rsn == `PCM_RSN_OPEN_TMO
        |=> o_state == MGR_WAIT_CLOSE_STATE)
        else $error("timeout not to wait close");
    a_collided: assert property (
        @(posedge i_clock) disable iff (i_sys_rst)
        o_state == MGR_REQUEST_WAIT_STATE && i_ce && !i_hard_reset &&
        !i_phy_disabled && !i_conn_opened && i_inb_rejected
        |=> o_oc_retry && o_oc_rsn == `PCM_RSN_COLLIDED)
        else $error("collided retry missing");
endmodule : pcm_manager

// file: hw/pcm_params.svh
`ifndef PCM_PARAMS_SVH
`define PCM_PARAMS_SVH
// ==========================================================
// Timing
`define PCM_CLK_NS 40
`define PCM_AWT_UNIT_NS 1000
`define PCM_AWT_TICK_CYC (`PCM_AWT_UNIT_NS / `PCM_CLK_NS)
// ==========================================================
// Reason codes (open failed from link)
`define PCM_RSN_PATH_BLOCKED 4'h0
`define PCM_RSN_RETRY 4'h1
`define PCM_RSN_NO_DEST 4'h2
`define PCM_RSN_BAD_DEST 4'h3
`define PCM_RSN_RATE_NS 4'h4
`define PCM_RSN_PROTO_NS 4'h5
`define PCM_RSN_TUN_BUSY 4'h6
`define PCM_RSN_WRONG_DEST 4'h7
`define PCM_RSN_OPEN_TMO 4'h8
`define PCM_RSN_BREAK_RX 4'h9
`define PCM_RSN_PL_REQ 4'ha
// Retry qualifiers beyond the open-failed reasons
`define PCM_RSN_BY_DEST 4'hb
`define PCM_RSN_BY_OTHER 4'hc
`define PCM_RSN_COLLIDED 4'hd
`endif

// file: hw/pcm_pkg.sv
package pcm_pkg;
    // Open request fields
    typedef struct packed {
        logic init_bit;
        logic [3:0] protocol;
        logic [3:0] rate;
        logic [15:0] conn_tag;
        logic [63:0] dest_addr;
        logic [63:0] src_addr;
        logic [15:0] pbc;
        logic [15:0] awt;
    } pcm_open_s;
    typedef enum logic [1:0] {
        MGR_IDLE_STATE,
        MGR_REQUEST_WAIT_STATE,
        MGR_CONNECTED_STATE,
        MGR_WAIT_CLOSE_STATE
    } pcm_state_e;
endpackage : pcm_pkg

// file: hw/pcm_timer_if.sv
`timescale 1ns/100ps
// ==========================================================
// Arbitration wait timer control
interface pcm_timer_if;
    logic load;
    logic run;
    logic [15:0] init;
    logic [15:0] value;
    modport mgr (output load, output run, output init, input value);
    modport tmr (input load, input run, input init, output value);
endinterface : pcm_timer_if

// file: hw/pcm_awt_timer.sv
`timescale 1ns/100ps
`include "pcm_params.svh"
// ==========================================================
// Arbitration wait timer: counts up in fixed units while running
module pcm_awt_timer import pcm_pkg::*; #(
    parameter int TICK_CYC = `PCM_AWT_TICK_CYC
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    pcm_timer_if.tmr tif
);
    typedef struct packed {
        logic [15:0] pre;
        logic [15:0] val;
    } pcm_tmr_s;
    pcm_tmr_s st_ff;
    pcm_tmr_s nxt_st;

    // Load wins; saturate so the value never wraps to a small time
    always_comb begin
        nxt_st = st_ff;
        if (tif.load) begin
            nxt_st.val = tif.init;
            nxt_st.pre = 16'h0;
        end else if (tif.run) begin
            if (st_ff.pre == 16'(TICK_CYC - 1)) begin
                nxt_st.pre = 16'h0;
                if (st_ff.val != 16'hffff)
                    nxt_st.val = st_ff.val + 16'h1;
            end else begin
                nxt_st.pre = st_ff.pre + 16'h1;
            end
        end
    end

    // Enable low holds both prescaler and count
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            st_ff <= '0;
        else if (i_ce)
            st_ff <= nxt_st;
    end

    assign tif.value = st_ff.val;
endmodule : pcm_awt_timer

// file: tb/pcm_link_model.sv
`timescale 1ns/100ps
// ==========================================================
// Link layer stand-in: answers an open after a set delay
module pcm_link_model (
    input wire logic i_clock,
    input wire logic i_open,
    input wire logic i_kick,
    input wire logic [2:0] i_kind,
    input wire logic [3:0] i_rsn,
    input wire logic [7:0] i_dly,
    output logic o_opened,
    output logic o_by_us,
    output logic o_by_dest,
    output logic o_failed,
    output logic [3:0] o_rsn,
    output logic o_rejected
);
    int cnt = -1;
    initial {o_opened, o_by_us, o_by_dest, o_failed, o_rsn} = '0;
    initial o_rejected = 1'b0;
    // Qualifiers toggle between answers so a stale value never matches
    always @(posedge i_clock) begin
        if (cnt == 0) begin
            o_opened <= #1 (i_kind inside {3'h1, 3'h2, 3'h3});
            o_by_us <= #1 (i_kind == 3'h1);
            o_by_dest <= #1 (i_kind == 3'h2);
            o_failed <= #1 (i_kind == 3'h0);
            o_rsn <= #1 i_rsn;
            o_rejected <= #1 (i_kind == 3'h4);
        end else begin
            {o_opened, o_failed, o_rejected} <= #1 3'h0;
            o_by_us <= #1 ~o_by_us;
            o_by_dest <= #1 ~o_by_dest;
            o_rsn <= #1 ~o_rsn;
        end
        if (i_open || i_kick) cnt = i_dly;
        else if (cnt >= 0) cnt = cnt - 1;
    end
endmodule : pcm_link_model

// file: tb/phy_manager_connection_request_tb_top.sv
`timescale 1ns/100ps
`include "pcm_params.svh"
module phy_manager_connection_request_tb_top import pcm_pkg::*;;
    logic i_clock = 0, i_sys_rst = 1, kick = 0, phy_en = 0, phy_dis = 0;
    logic open_req = 0, cancel = 0, hard_rst = 0, conn_done = 0, ce = 1;
    logic [2:0] kind = 3'h5;
    logic [3:0] rsn = 4'h0, l_rsn, o_oc_rsn;
    logic [7:0] dly = 8'h00;
    logic opened, by_us, by_dest, failed, rejected;
    logic o_link_open, o_link_stop_arb, o_oc_opened, o_oc_retry, o_oc_nocon;
    pcm_open_s o_link_args, o_oc_args, nocon;
    pcm_state_e o_state;
    int n_errors = 0, n_checks = 0;
    pcm_open_s req = {1'h1, 4'h2, 4'h9, 16'h1234, 64'h5000_0000_0000_00aa,
        64'h5000_0000_0000_00bb, 16'h0007, 16'h0100};
    assign nocon = {9'h0, req.conn_tag, req.dest_addr, req.src_addr, 32'h0};
    pcm_manager i_pcm_manager (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_ce(ce), .i_phy_enabled(phy_en), .i_phy_disabled(phy_dis),
        .i_open_req(open_req), .i_open(req), .i_cancel_open(cancel),
        .i_conn_opened(opened), .i_opened_by_us(by_us),
        .i_opened_by_dest(by_dest), .i_open_failed(failed),
        .i_fail_rsn(l_rsn), .i_inb_rejected(rejected),
        .i_hard_reset(hard_rst), .i_conn_done(conn_done),
        .o_link_open(o_link_open), .o_link_args(o_link_args),
        .o_link_stop_arb(o_link_stop_arb), .o_oc_opened(o_oc_opened),
        .o_oc_retry(o_oc_retry), .o_oc_nocon(o_oc_nocon),
        .o_oc_rsn(o_oc_rsn), .o_oc_args(o_oc_args), .o_state(o_state));
    pcm_link_model i_pcm_link_model (.i_clock(i_clock),
        .i_open(o_link_open), .i_kick(kick), .i_kind(kind), .i_rsn(rsn),
        .i_dly(dly), .o_opened(opened), .o_by_us(by_us),
        .o_by_dest(by_dest), .o_failed(failed), .o_rsn(l_rsn),
        .o_rejected(rejected));
    // ==========================================================
    // Helpers
    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // Inputs move 1 ns after the edge, outputs are read there too
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic pulse(input int w);
        case (w)
            0: phy_en = 1;
            1: phy_dis = 1;
            2: open_req = 1;
            3: cancel = 1;
            4: hard_rst = 1;
            5: conn_done = 1;
            default: kick = 1;
        endcase
        tick(1);
        {phy_en, phy_dis, open_req, cancel, hard_rst, conn_done, kick} = '0;
    endtask : pulse
    task automatic wait_msg();
        int i;
        for (i = 0; i < 200 && (o_oc_retry | o_oc_nocon | o_oc_opened)
            !== 1'b1; i++) tick(1);
        if (i == 200) begin
            n_errors++;
            close_out();
        end
    endtask : wait_msg
    task automatic do_open(input logic [2:0] k, input logic [7:0] d);
        kind = k;
        dly = d;
        pulse(2);
        chk(o_link_open, 1'b1);
        chk(o_state, MGR_REQUEST_WAIT_STATE);
        chk(o_link_args, req);
    endtask : do_open
    // ==========================================================
    // Scenarios
    task automatic t_fail();
        for (int r = 0; r < 11; r++) begin
            rsn = 4'(r);
            do_open(3'h0, 8'h00);
            if (r >= 8) begin
                tick(3);
                chk(o_oc_retry | o_oc_nocon | o_oc_opened, 1'b0);
                chk(o_state, MGR_WAIT_CLOSE_STATE);
                pulse(5);
            end else begin
                wait_msg();
                chk({o_oc_retry, o_oc_nocon}, {r < 3, r >= 3});
                chk(o_oc_rsn, rsn);
                if (r < 3)
                    chk(o_oc_args[184:16], req[184:16]);
                else
                    chk(o_oc_args, nocon);
                chk(o_state, MGR_IDLE_STATE);
            end
        end
    endtask : t_fail
    // Failure after 63 cycles in request wait: timer two units on
    task automatic t_timer();
        rsn = 4'h1;
        do_open(3'h0, 8'd60);
        wait_msg();
        chk(o_oc_args.awt, req.awt + 16'h2);
    endtask : t_timer
    task automatic t_opened();
        for (int k = 1; k < 4; k++) begin
            do_open(3'(k), 8'h00);
            wait_msg();
            chk(o_oc_opened, 1'b1);
            chk(o_oc_retry, k != 1);
            if (k != 1) begin
                rsn = k == 2 ? `PCM_RSN_BY_DEST : `PCM_RSN_BY_OTHER;
                chk(o_oc_rsn, rsn);
                chk(o_oc_args[184:16], req[184:16]);
            end
            chk(o_state, MGR_CONNECTED_STATE);
            pulse(5);
        end
    endtask : t_opened
    task automatic t_abort();
        do_open(3'h4, 8'h00);
        wait_msg();
        chk({o_oc_retry, o_oc_rsn}, {1'b1, `PCM_RSN_COLLIDED});
        do_open(3'h5, 8'h00);
        pulse(3);
        chk(o_link_stop_arb, 1'b1);
        // Enable low freezes the manager and its timer, so the hard reset is not seen
        ce = 0;
        pulse(4);
        chk({o_state, o_link_stop_arb}, {MGR_REQUEST_WAIT_STATE, 1'b1});
        ce = 1;
        pulse(4);
        chk({o_state, o_oc_retry}, {MGR_IDLE_STATE, 1'b0});
        do_open(3'h5, 8'h00);
        pulse(1);
        chk(o_state, MGR_IDLE_STATE);
        pulse(2);
        tick(2);
        chk({o_link_open, o_state}, {1'b0, MGR_IDLE_STATE});
        kind = 3'h1;
        pulse(6);
        tick(2);
        chk(o_state, MGR_CONNECTED_STATE);
    endtask : t_abort
    // ==========================================================
    // Clock, reset and main sequence
    initial forever #20 i_clock = ~i_clock;
    initial begin
        tick(5);
        i_sys_rst = 0;
        chk({o_state, o_link_open}, {MGR_IDLE_STATE, 1'b0});
        pulse(2);
        tick(2);
        chk(o_state, MGR_IDLE_STATE);
        pulse(0);
        t_fail();
        t_timer();
        t_opened();
        t_abort();
        close_out();
    end
endmodule : phy_manager_connection_request_tb_top
